// ==== core/sbs_cfg.svh ====
// sizes, field values and timing counts of the byte shifter
`ifndef SBS_CFG_SVH
`define SBS_CFG_SVH

// data path
`define SBS_DATA_W 8
`define SBS_FIFO_DEPTH 32

// sck half periods in system clocks, indexed {double, rate[1:0]}
`define SBS_HALF_W 7
`define SBS_HALF_R0 7'h02
`define SBS_HALF_R1 7'h08
`define SBS_HALF_R2 7'h20
`define SBS_HALF_R3 7'h40
`define SBS_HALF_R4 7'h01
`define SBS_HALF_R5 7'h04
`define SBS_HALF_R6 7'h10
`define SBS_HALF_R7 7'h20

// edge and bit counts of one byte
`define SBS_CTL_LAST_EDGE 4'hF
`define SBS_TGT_LAST_BIT 4'h7

// synchroniser reset value, order {mosi, ss, sck}
`define SBS_SYNC_RST 3'h2

// least sck phase the far controller must keep, in system clocks
`define SBS_SCK_MIN_PHASE 2

`endif

// ==== core/sbs_pkg.sv ====
// types shared by the byte shifter modules
package sbs_pkg;

   // controller sequencer, gray coded along idle-hold-run
   typedef enum logic [1:0] {
      SBS_IDLE = 2'b00,
      SBS_HOLD = 2'b01,
      SBS_RUN = 2'b11
   } sbs_state_t;

   typedef logic [7:0] sbs_byte_t;

endpackage

// ==== core/sbs_stream_if.sv ====
// valid/ready byte stream between shifter and receive fifo
`timescale 1ns/10ps
`default_nettype none

interface sbs_stream_if #(parameter int W = 8);
   logic valid;
   logic ready;
   logic [W-1:0] data;
   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface

`default_nettype wire

// ==== core/sbs_rate_div.sv ====
// sck half-period divider giving one-cycle tick pulses
`timescale 1ns/10ps
`default_nettype none

module sbs_rate_div #(
   parameter int CW = 7
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic run,
   input wire logic [CW-1:0] half,
   output logic tick
);

   logic [CW-1:0] cnt;

   // tick on the last count of each half period
   assign tick = run && (cnt == half - {{(CW-1){1'b0}}, 1'b1});

   // count restarts whenever the clock generator halts
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cnt <= '0;
      end else if (!run || tick) begin
         cnt <= '0;
      end else begin
         cnt <= cnt + {{(CW-1){1'b0}}, 1'b1};
      end
   end

endmodule

`default_nettype wire

// ==== core/sbs_fifo.sv ====
// receive fifo with parameter width and depth
`timescale 1ns/10ps
`default_nettype none

module sbs_fifo #(
   parameter int W = 8,
   parameter int D = 32
) (
   input wire logic clk,
   input wire logic rst,
   sbs_stream_if.snk wr,
   output logic rd_valid,
   input wire logic rd_ready,
   output logic [W-1:0] rd_data
);

   localparam int AW = $clog2(D);

   logic [W-1:0] mem [D];
   logic [AW:0] wp;
   logic [AW:0] rp;
   wire full;
   wire empty;
   wire push;
   wire pop;

   // pointers carry one wrap bit for honest full and empty
   assign full = (wp[AW] != rp[AW]) && (wp[AW-1:0] == rp[AW-1:0]);
   assign empty = (wp == rp);
   assign push = wr.valid && !full;
   assign pop = !empty && rd_ready;
   assign wr.ready = !full;
   assign rd_valid = !empty;
   assign rd_data = mem[rp[AW-1:0]];

   // pointer update
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wp <= '0;
         rp <= '0;
      end else begin
         if (push) wp <= wp + 1'b1;
         if (pop) rp <= rp + 1'b1;
      end
   end

   // storage
   always_ff @(posedge clk) begin
      if (push) mem[wp[AW-1:0]] <= wr.data;
   end

endmodule

`default_nettype wire

// ==== core/sbs_byte_shifter.sv ====
// byte serial port working as controller or target, with receive fifo
//
// Operation
// RULE_01: data write starts clock, shifts eight bits
// RULE_02: clock halts after byte, done flag set
// RULE_03: done flag with enable raises interrupt
// RULE_04: software drives select line in controller mode
// RULE_05: controller writes next byte or ends packet
// RULE_06: last received byte held in buffer
// RULE_07: target idle, data out tri-stated, select high
// RULE_08: target accepts writes while select high
// RULE_09: target sets done flag after full byte
// RULE_10: target may load next byte before reading
// RULE_11: no new byte until shift completes
// RULE_12: receive byte must be read before next
// RULE_13: far clock phases exceed two system clocks
// RULE_14: enabled port overrides pin directions by mode
// RULE_15: controller selects target low, releases high
// RULE_16: power reduce bit must be zero
// RULE_17: seven distinct controller bit rates
// RULE_18: double speed runs sck at half clock
// RULE_19: bit order selectable, lsb or msb first
// RULE_20: write during transfer sets collision flag
// RULE_21: full duplex, both data lines per edge
// RULE_22: completion interrupt wakes from idle
// RULE_23: select high resets target shift logic
// RULE_24: select low as input forces target mode
// RULE_25: done cleared by vector or status-data access
// RULE_26: setup one edge, sample opposite, polarity, phase
// RULE_27: target clock and select double synchronised
`include "sbs_cfg.svh"
`timescale 1ns/10ps
`default_nettype none

module sbs_byte_shifter import sbs_pkg::*; #(
   parameter int FIFO_DEPTH = `SBS_FIFO_DEPTH
) (
   input wire logic MCLK,
   input wire logic RESET,
   input wire logic PORT_EN,
   input wire logic POWER_REDUCE,
   input wire logic IRQ_EN,
   input wire logic LSB_FIRST,
   input wire logic CLK_POL,
   input wire logic CLK_PHA,
   input wire logic [1:0] RATE_SEL,
   input wire logic DOUBLE_SPEED,
   input wire logic MODE_WR,
   input wire logic MODE_VAL,
   input wire logic DIR_MOSI,
   input wire logic DIR_MISO,
   input wire logic DIR_SCK,
   input wire logic DIR_SS,
   input wire logic DATA_WR,
   input wire logic [7:0] DATA_WDATA,
   input wire logic DATA_RD,
   input wire logic STATUS_RD,
   input wire logic IRQ_ACK,
   input wire logic SCK_I,
   output logic SCK_O,
   output logic SCK_OE_N,
   input wire logic MOSI_I,
   output logic MOSI_O,
   output logic MOSI_OE_N,
   input wire logic MISO_I,
   output logic MISO_O,
   output logic MISO_OE_N,
   input wire logic SS_I,
   output logic [7:0] RX_DATA,
   output logic DONE_FLAG,
   output logic COLLISION_FLAG,
   output logic IRQ,
   output logic CONTROLLER_MODE,
   output logic BUSY,
   output logic RX_STREAM_VALID,
   input wire logic RX_STREAM_READY,
   output logic [7:0] RX_STREAM_DATA
);

   // ***************************************************
   // state and wires
   // ***************************************************
   localparam logic [`SBS_HALF_W-1:0] HALF_TAB [8] = '{
      `SBS_HALF_R0, `SBS_HALF_R1, `SBS_HALF_R2, `SBS_HALF_R3,
      `SBS_HALF_R4, `SBS_HALF_R5, `SBS_HALF_R6, `SBS_HALF_R7};

   sbs_state_t state;
   sbs_state_t next_state;
   sbs_byte_t shreg;
   sbs_byte_t rx_buf;
   logic [3:0] cnt;
   logic [3:0] next_cnt;
   logic controller_select_bit;
   logic done;
   logic write_collision_flag;
   logic status_seen;
   logic sck_lvl;
   logic out_bit;
   logic [2:0] sync1;
   logic [2:0] sync2;
   logic sck_s3;
   logic tick;

   wire en;
   wire ss_hi;
   wire sck_s2;
   wire mosi_s2;
   wire ctl_run;
   wire ctl_edge;
   wire tgt_act;
   wire tgt_edge;
   wire edge_ev;
   wire leading;
   wire sample_ev;
   wire setup_ev;
   wire in_bit;
   wire [7:0] shifted;
   wire [7:0] rx_next;
   wire done_ctl;
   wire done_tgt;
   wire done_any;
   wire busy;
   wire wr_ok;
   wire fallback;
   wire flag_clr;
   wire fifo_ready;
   wire [`SBS_HALF_W-1:0] half;

   sbs_stream_if #(.W(8)) push_if ();

   // ***************************************************
   // enable, synchronised pins, rate selection
   // ***************************************************
   assign en = PORT_EN && !POWER_REDUCE;
   assign sck_s2 = sync2[0];
   assign ss_hi = sync2[1];
   assign mosi_s2 = sync2[2];
   assign half = HALF_TAB[{DOUBLE_SPEED, RATE_SEL}]; // [RULE_17] [RULE_18]

   // two-stage synchroniser on sck, select and mosi
   always_ff @(posedge MCLK or posedge RESET) begin // [RULE_27] [RULE_13]
      if (RESET) begin
         sync1 <= `SBS_SYNC_RST;
         sync2 <= `SBS_SYNC_RST;
         sck_s3 <= 1'b0;
      end else begin
         sync1 <= {MOSI_I, SS_I, SCK_I};
         sync2 <= sync1;
         sck_s3 <= sync2[0];
      end
   end

   sbs_rate_div #(.CW(`SBS_HALF_W)) u_div (
      .clk(MCLK),
      .rst(RESET),
      .run(ctl_run),
      .half(half),
      .tick(tick)
   );

   // ***************************************************
   // edge decoding for both modes
   // ***************************************************
   assign ctl_run = en && controller_select_bit && (state == SBS_RUN);
   assign ctl_edge = ctl_run && tick;
   assign tgt_act = en && !controller_select_bit && !ss_hi; // [RULE_07]
   assign tgt_edge = tgt_act && (sck_s2 != sck_s3);
   assign edge_ev = ctl_edge || tgt_edge;
   assign leading = controller_select_bit ? !cnt[0] : (sck_s2 != CLK_POL);
   assign sample_ev = edge_ev && (leading != CLK_PHA); // [RULE_26]
   assign setup_ev = edge_ev && (leading == CLK_PHA); // [RULE_26]
   assign in_bit = controller_select_bit ? MISO_I : mosi_s2; // [RULE_21]
   assign shifted = LSB_FIRST ? {in_bit, shreg[7:1]} // [RULE_19]
                              : {shreg[6:0], in_bit};
   assign rx_next = sample_ev ? shifted : shreg;

   // completion, busy and write acceptance
   assign done_ctl = ctl_edge && (cnt == `SBS_CTL_LAST_EDGE); // [RULE_02]
   assign done_tgt = tgt_edge && sample_ev
                     && (cnt == `SBS_TGT_LAST_BIT); // [RULE_09]
   assign done_any = done_ctl || done_tgt;
   assign busy = controller_select_bit ? (state != SBS_IDLE) : (tgt_act && cnt != 4'h0);
   assign wr_ok = DATA_WR && en && !busy; // [RULE_11] [RULE_08] [RULE_10]
   assign fallback = en && controller_select_bit && !DIR_SS && !SS_I; // [RULE_24]
   assign flag_clr = status_seen && (DATA_WR || DATA_RD); // [RULE_25]
   assign fifo_ready = push_if.ready;

   // ***************************************************
   // controller sequencer
   // ***************************************************
   always_comb begin
      next_state = state;
      unique case (state)
         SBS_IDLE: begin
            if (wr_ok && controller_select_bit) next_state = SBS_HOLD; // [RULE_01]
         end
         SBS_HOLD: begin
            if (fifo_ready) next_state = SBS_RUN;
         end
         SBS_RUN: begin
            if (done_ctl) next_state = SBS_IDLE; // [RULE_02]
         end
         default: next_state = SBS_IDLE;
      endcase
      if (!en || !controller_select_bit || fallback) next_state = SBS_IDLE;
   end

   // edge counter: all edges as controller, sample edges as target
   always_comb begin
      next_cnt = cnt;
      if (!en || (!controller_select_bit && ss_hi) || (controller_select_bit && state != SBS_RUN)) begin
         next_cnt = 4'h0; // [RULE_23]
      end else if (ctl_edge) begin
         next_cnt = cnt + 4'h1;
      end else if (tgt_edge && sample_ev) begin
         next_cnt = done_tgt ? 4'h0 : cnt + 4'h1;
      end
   end

   // state and counter registers
   always_ff @(posedge MCLK or posedge RESET) begin
      if (RESET) begin
         state <= SBS_IDLE;
         cnt <= 4'h0;
      end else begin
         state <= next_state;
         cnt <= next_cnt;
      end
   end

   // ***************************************************
   // shift register and data output bit
   // ***************************************************
   always_ff @(posedge MCLK or posedge RESET) begin
      if (RESET) begin
         shreg <= 8'h00;
         out_bit <= 1'b0;
      end else if (wr_ok) begin
         shreg <= DATA_WDATA;
         out_bit <= LSB_FIRST ? DATA_WDATA[0] : DATA_WDATA[7];
      end else begin
         if (sample_ev) shreg <= shifted; // [RULE_21]
         if (setup_ev || (!controller_select_bit && ss_hi)) begin
            out_bit <= LSB_FIRST ? shreg[0] : shreg[7];
         end
      end
   end

   // controller clock level, idle at the chosen polarity
   always_ff @(posedge MCLK or posedge RESET) begin
      if (RESET) begin
         sck_lvl <= 1'b0;
      end else if (!ctl_run) begin
         sck_lvl <= CLK_POL; // [RULE_26]
      end else if (ctl_edge) begin
         sck_lvl <= !sck_lvl;
      end
   end

   // receive buffer, overwritten by every completed byte
   always_ff @(posedge MCLK or posedge RESET) begin
      if (RESET) begin
         rx_buf <= 8'h00;
      end else if (done_any) begin
         rx_buf <= rx_next; // [RULE_06] [RULE_12]
      end
   end

   // ***************************************************
   // mode bit and status flags
   // ***************************************************
   always_ff @(posedge MCLK or posedge RESET) begin
      if (RESET) begin
         controller_select_bit <= 1'b0;
      end else if (fallback) begin
         controller_select_bit <= 1'b0; // [RULE_24]
      end else if (MODE_WR) begin
         controller_select_bit <= MODE_VAL;
      end
   end

   // flags: a new set of done or collision wins over a clear in the same cycle
   always_ff @(posedge MCLK or posedge RESET) begin
      if (RESET) begin
         done <= 1'b0;
         write_collision_flag <= 1'b0;
         status_seen <= 1'b0;
      end else begin
         done <= done_any || fallback
                 || (done && !flag_clr && !IRQ_ACK); // [RULE_25]
         write_collision_flag <= (DATA_WR && en && busy) || (write_collision_flag && !flag_clr); // [RULE_20]
         if (DATA_WR || DATA_RD) begin
            status_seen <= 1'b0;
         end else if (STATUS_RD && (done || write_collision_flag)) begin
            status_seen <= 1'b1;
         end
      end
   end

   // ***************************************************
   // receive stream fifo
   // ***************************************************
   assign push_if.valid = done_any;
   assign push_if.data = rx_next;

   sbs_fifo #(.W(8), .D(FIFO_DEPTH)) u_fifo (
      .clk(MCLK),
      .rst(RESET),
      .wr(push_if),
      .rd_valid(RX_STREAM_VALID),
      .rd_ready(RX_STREAM_READY),
      .rd_data(RX_STREAM_DATA)
   );

   // ***************************************************
   // pins and status outputs
   // ***************************************************
   assign SCK_O = sck_lvl;
   assign MOSI_O = out_bit;
   assign MISO_O = out_bit;
   assign SCK_OE_N = !(en && controller_select_bit && DIR_SCK); // [RULE_14]
   assign MOSI_OE_N = !(en && controller_select_bit && DIR_MOSI); // [RULE_14]
   assign MISO_OE_N = !(tgt_act && DIR_MISO); // [RULE_14] [RULE_07]
   assign RX_DATA = rx_buf;
   assign DONE_FLAG = done;
   assign COLLISION_FLAG = write_collision_flag;
   assign IRQ = done && IRQ_EN; // [RULE_03] [RULE_22]
   assign CONTROLLER_MODE = controller_select_bit;
   assign BUSY = busy;

   // ***************************************************
   // assertions
   // ***************************************************
   default clocking cb @(posedge MCLK); endclocking
   default disable iff (RESET);

   property p_start;
      (state == SBS_IDLE) && wr_ok && controller_select_bit && !fallback && fifo_ready
      |=> (state == SBS_HOLD) ##1 (state == SBS_RUN);
   endproperty
   a_start: assert property (p_start) else $error("start lost"); // [RULE_01]

   property p_halt;
      done_ctl && !fallback |=> (state == SBS_IDLE) && done && !ctl_run;
   endproperty
   a_halt: assert property (p_halt) else $error("no halt"); // [RULE_02]

   property p_irq;
      done_any |=> DONE_FLAG && (IRQ == IRQ_EN);
   endproperty
   a_irq: assert property (p_irq) else $error("irq missing"); // [RULE_03]

   property p_rxbuf;
      done_any |=> (RX_DATA == $past(rx_next)) && RX_DATA == rx_buf;
   endproperty
   a_rxbuf: assert property (p_rxbuf) else $error("rx buffer"); // [RULE_06]

   property p_tri;
      !controller_select_bit && ss_hi |-> MISO_OE_N && (cnt == 4'h0 || $rose(ss_hi));
   endproperty
   a_tri: assert property (p_tri) else $error("target drives"); // [RULE_07]

   property p_ssreset;
      !controller_select_bit && ss_hi |=> cnt == 4'h0;
   endproperty
   a_ssreset: assert property (p_ssreset) else $error("no reset"); // [RULE_23]

   property p_fallback;
      fallback |=> !controller_select_bit && done && state == SBS_IDLE && SCK_OE_N;
   endproperty
   a_fallback: assert property (p_fallback) else $error("fallback"); // [RULE_24]

   property p_write_collision_flag;
      DATA_WR && en && busy |=> COLLISION_FLAG && shreg == $past(rx_next);
   endproperty
   a_write_collision_flag: assert property (p_write_collision_flag) else $error("collision"); // [RULE_20]

   property p_miso_in;
      en && controller_select_bit |-> MISO_OE_N;
   endproperty
   a_miso_in: assert property (p_miso_in) else $error("miso out"); // [RULE_14]

   property p_double;
      ctl_run && DOUBLE_SPEED && RATE_SEL == 2'b00 |-> tick;
   endproperty
   a_double: assert property (p_double) else $error("half rate"); // [RULE_18]

   property p_clear;
      IRQ_ACK && !done_any && !fallback |=> !done;
   endproperty
   a_clear: assert property (p_clear) else $error("flag stuck"); // [RULE_25]

   c_ctl_done: cover property (done_ctl);
   c_tgt_done: cover property (done_tgt);
   c_fallback: cover property (fallback);
   c_hold: cover property (state == SBS_HOLD ##1 state == SBS_HOLD);

endmodule

`default_nettype wire

// ==== tb/sbs_far_peer.sv ====
// behavioural far-side peer: spi target (modes 0 and 3) or controller, msb first
`timescale 1ns/10ps
`default_nettype none

module sbs_far_peer import sbs_pkg::*; (
   input wire logic clk,
   input wire logic sck_in,
   input wire logic mosi_in,
   input wire logic miso_in,
   output logic sck_out,
   output logic mosi_out,
   output logic miso_out,
   output logic ss_n
);
   logic ctl_role;
   logic got;
   sbs_byte_t tx_sh;
   sbs_byte_t rx_sh;

   // idle pins at time zero
   initial begin
      ctl_role = 1'b0;
      got = 1'b0;
      sck_out = 1'b0;
      mosi_out = 1'b0;
      ss_n = 1'b1;
      tx_sh = 8'h00;
      rx_sh = 8'h00;
   end

   // target role samples on rising sck, sets up on falling
   always @(posedge sck_in) begin
      if (!ss_n && !ctl_role) begin
         rx_sh <= {rx_sh[6:0], mosi_in};
         got <= 1'b1;
      end
   end
   // first bit stays until one sample, so a leading setup edge keeps it
   always @(negedge sck_in) begin
      if (!ss_n && !ctl_role && got) begin
         tx_sh <= {tx_sh[6:0], ~tx_sh[7]};
      end
   end

   // a deselected target lets miso wander off its last value
   assign miso_out = ss_n ? ~tx_sh[7] : tx_sh[7];

   // software select of the peer, low opens, high ends the packet
   task automatic select(input logic lvl, input logic role, input sbs_byte_t b);
      @(posedge clk);
      #1;
      ctl_role = role;
      got = 1'b0;
      tx_sh = b;
      ss_n = lvl;
   endtask

   // controller role: n bits, each sck phase half clocks long
   task automatic shift(input sbs_byte_t b, input int n, input int half,
                        output sbs_byte_t r);
      r = 8'h00;
      for (int i = 7; i > 7 - n; i--) begin
         mosi_out = b[i];
         repeat (half) @(posedge clk);
         #1 sck_out = 1'b1;
         r[i] = miso_in;
         repeat (half) @(posedge clk);
         #1 sck_out = 1'b0;
      end
   endtask
endmodule

`default_nettype wire

// ==== tb/test_spi_byte_shifter.sv ====
// self-checking testbench of the byte shifter with its far-side peer
`timescale 1ns/10ps
`default_nettype none

module test_spi_byte_shifter import sbs_pkg::*; ;
   logic mclk, reset, port_en, power_reduce, irq_en, lsb_first, clk_pol;
   logic clk_pha, double_speed, mode_wr, mode_val, dir_mosi, dir_miso;
   logic dir_sck, dir_ss, data_wr, data_rd, status_rd, irq_ack, rx_ready;
   logic [1:0] rate_sel;
   logic [7:0] data_wdata, rx_data, rx_stream_data;
   logic sck_o, sck_oe_n, mosi_o, mosi_oe_n, miso_o, miso_oe_n, done_flag;
   logic collision_flag, irq, controller_mode, busy, rx_stream_valid;
   logic p_sck, p_mosi, p_miso, p_ss_n;
   int num_errors = 0;
   int checks = 0;
   int half_tab [8] = '{2, 8, 32, 64, 1, 4, 16, 32};
   sbs_byte_t r;
   // resolved pin levels from the dut's enables
   wire sck_w = sck_oe_n ? p_sck : sck_o;
   wire mosi_w = mosi_oe_n ? p_mosi : mosi_o;
   wire miso_w = miso_oe_n ? p_miso : miso_o;

   sbs_byte_shifter dut (.MCLK(mclk), .RESET(reset), .PORT_EN(port_en),
      .POWER_REDUCE(power_reduce), .IRQ_EN(irq_en), .LSB_FIRST(lsb_first),
      .CLK_POL(clk_pol), .CLK_PHA(clk_pha), .RATE_SEL(rate_sel),
      .DOUBLE_SPEED(double_speed), .MODE_WR(mode_wr), .MODE_VAL(mode_val),
      .DIR_MOSI(dir_mosi), .DIR_MISO(dir_miso), .DIR_SCK(dir_sck),
      .DIR_SS(dir_ss), .DATA_WR(data_wr), .DATA_WDATA(data_wdata),
      .DATA_RD(data_rd), .STATUS_RD(status_rd), .IRQ_ACK(irq_ack),
      .SCK_I(sck_w), .SCK_O(sck_o), .SCK_OE_N(sck_oe_n), .MOSI_I(mosi_w),
      .MOSI_O(mosi_o), .MOSI_OE_N(mosi_oe_n), .MISO_I(miso_w),
      .MISO_O(miso_o), .MISO_OE_N(miso_oe_n), .SS_I(p_ss_n),
      .RX_DATA(rx_data), .DONE_FLAG(done_flag),
      .COLLISION_FLAG(collision_flag), .IRQ(irq),
      .CONTROLLER_MODE(controller_mode), .BUSY(busy),
      .RX_STREAM_VALID(rx_stream_valid), .RX_STREAM_READY(rx_ready),
      .RX_STREAM_DATA(rx_stream_data));

   sbs_far_peer peer (.clk(mclk), .sck_in(sck_w), .mosi_in(mosi_w),
      .miso_in(miso_w), .sck_out(p_sck), .mosi_out(p_mosi),
      .miso_out(p_miso), .ss_n(p_ss_n));

   // ***************
   // helpers
   // ***************
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask
   task automatic wr_byte(input sbs_byte_t b);
      data_wdata = b;
      data_wr = 1'b1;
      tick(1);
      data_wr = 1'b0;
   endtask
   task automatic set_mode(input logic v);
      mode_val = v;
      mode_wr = 1'b1;
      tick(1);
      mode_wr = 1'b0;
   endtask
   task automatic ack;
      irq_ack = 1'b1;
      tick(1);
      irq_ack = 1'b0;
      tick(1);
   endtask
   // status read with a flag set, then data read, clears both flags
   task automatic sd_clear;
      status_rd = 1'b1;
      tick(1);
      status_rd = 1'b0;
      data_rd = 1'b1;
      tick(1);
      data_rd = 1'b0;
      tick(1);
   endtask
   task automatic wait_done(input int lim);
      for (int i = 0; i < lim && done_flag !== 1'b1; i++) tick(1);
   endtask
   task automatic finish_test;
      $display("checks %0d num_errors %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   // ***************
   // scenarios
   // ***************
   task automatic t_reset;
      check(done_flag, 1'b0);
      check(controller_mode, 1'b0);
      check(rx_data, 8'h00);
      check({sck_oe_n, mosi_oe_n, miso_oe_n}, 3'h7);
      check(rx_stream_valid, 1'b0);
      set_mode(1'b1);
      clk_pol = 1'b1;
      tick(3);
      check(sck_o, 1'b1);
      clk_pol = 1'b0;
      tick(3);
      check(sck_o, 1'b0);
      check({sck_oe_n, mosi_oe_n, miso_oe_n}, 3'h1);
   endtask

   task automatic t_ctl(input sbs_byte_t b, input sbs_byte_t pb,
                        input logic [2:0] rs, input logic coll);
      int gap;
      int toggles;
      int seen_gap;
      logic prev;
      sbs_byte_t exp_p;
      sbs_byte_t exp_r;
      {double_speed, rate_sel} = rs;
      lsb_first = rs[0];
      irq_en = rs[1];
      clk_pol = rs[2];
      clk_pha = rs[2];
      peer.select(1'b0, 1'b0, pb);
      wr_byte(b);
      toggles = 0;
      gap = 0;
      seen_gap = 0;
      prev = sck_o;
      for (int i = 0; i < 2200 && done_flag !== 1'b1; i++) begin
         data_wr = coll && toggles == 4 && gap == 0;
         data_wdata = ~b;
         tick(1);
         gap++;
         if (sck_o !== prev) begin
            toggles++;
            if (toggles > 1) seen_gap = gap;
            gap = 0;
            prev = sck_o;
         end
      end
      data_wr = 1'b0;
      // lsb first reverses the byte as the msb-first peer sees it
      for (int j = 0; j < 8; j++) begin
         exp_p[j] = rs[0] ? b[7-j] : b[j];
         exp_r[j] = rs[0] ? pb[7-j] : pb[j];
      end
      check(toggles[7:0], 8'h10);
      check(seen_gap[7:0], 8'(half_tab[rs]));
      check(done_flag, 1'b1);
      check(irq, rs[1]);
      check(rx_data, exp_r);
      check(peer.rx_sh, exp_p);
      check(collision_flag, coll);
      check(miso_oe_n, 1'b1);
      tick(4);
      check({busy, sck_o}, {1'b0, rs[2]});
      peer.select(1'b1, 1'b0, 8'h00);
      if (coll) sd_clear();
      else ack();
      check({done_flag, collision_flag}, 2'h0);
   endtask

   task automatic t_clear;
      power_reduce = 1'b1;
      wr_byte(8'h55);
      tick(40);
      check({done_flag, busy}, 2'h0);
      power_reduce = 1'b0;
      {double_speed, rate_sel} = 3'h4;
      irq_en = 1'b0;
      wr_byte(8'h55);
      wait_done(100);
      check(irq, 1'b0);
      irq_en = 1'b1;
      tick(1);
      check(irq, 1'b1);
      status_rd = 1'b1;
      tick(1);
      status_rd = 1'b0;
      tick(1);
      check(done_flag, 1'b1);
      data_rd = 1'b1;
      tick(1);
      data_rd = 1'b0;
      tick(1);
      check({done_flag, collision_flag}, 2'h0);
   endtask

   task automatic t_tgt;
      {clk_pol, clk_pha, lsb_first} = 3'h0;
      set_mode(1'b0);
      peer.select(1'b0, 1'b1, 8'h00);
      peer.shift(8'h00, 3, 6, r);
      peer.select(1'b1, 1'b1, 8'h00);
      tick(4);
      wr_byte(8'hC3);
      peer.shift(8'hFF, 8, 6, r);
      tick(4);
      check({done_flag, busy, miso_oe_n}, 3'h1);
      check({sck_oe_n, mosi_oe_n}, 2'h3);
      peer.select(1'b0, 1'b1, 8'h00);
      tick(6);
      check(miso_oe_n, 1'b0);
      peer.shift(8'h96, 8, 6, r);
      tick(4);
      check(done_flag, 1'b1);
      check(rx_data, 8'h96);
      check(r, 8'hC3);
      wr_byte(8'h5A);
      ack();
      peer.shift(8'h69, 8, 6, r);
      tick(4);
      check(r, 8'h5A);
      check(rx_data, 8'h69);
      peer.select(1'b1, 1'b1, 8'h00);
      tick(4);
      check(miso_oe_n, 1'b1);
      ack();
   endtask

   task automatic t_fall;
      set_mode(1'b1);
      dir_ss = 1'b0;
      peer.select(1'b0, 1'b1, 8'h00);
      tick(5);
      check({controller_mode, done_flag}, 2'h1);
      check(sck_oe_n, 1'b1);
      peer.select(1'b1, 1'b1, 8'h00);
      dir_ss = 1'b1;
      ack();
   endtask

   task automatic t_fifo;
      rx_ready = 1'b1;
      tick(40);
      rx_ready = 1'b0;
      check(rx_stream_valid, 1'b0);
      set_mode(1'b1);
      {double_speed, rate_sel} = 3'h4;
      lsb_first = 1'b0;
      for (int k = 0; k < 33; k++) begin
         peer.select(1'b0, 1'b0, 8'(k));
         wr_byte(8'(k));
         wait_done(60);
         ack();
      end
      check({busy, done_flag}, 2'h2);
      for (int k = 0; k < 33; k++) begin
         for (int i = 0; i < 60 && rx_stream_valid !== 1'b1; i++) tick(1);
         check(rx_stream_valid, 1'b1);
         check(rx_stream_data, 8'(k));
         rx_ready = 1'b1;
         tick(1);
         rx_ready = 1'b0;
      end
      tick(2);
      check(rx_stream_valid, 1'b0);
      peer.select(1'b1, 1'b0, 8'h00);
   endtask

   // clock and watchdog
   initial begin
      mclk = 1'b0;
      forever #2.5 mclk = ~mclk;
   end
   initial begin
      #200000;
      num_errors++;
      finish_test();
   end

   // main sequence
   initial begin
      {reset, port_en, dir_mosi, dir_sck, dir_ss, dir_miso} = 6'h3F;
      {power_reduce, irq_en, lsb_first, clk_pol, clk_pha} = 5'h00;
      {double_speed, rate_sel, mode_wr, mode_val} = 5'h00;
      {data_wr, data_rd, status_rd, irq_ack, rx_ready} = 5'h00;
      data_wdata = 8'h00;
      repeat (16) @(posedge mclk);
      #1 reset = 1'b0;
      tick(1);
      t_reset();
      for (int rs = 0; rs < 8; rs++) begin
         t_ctl(8'hA5 ^ 8'(rs), 8'h3C + 8'(rs), 3'(rs), rs == 1);
      end
      t_clear();
      t_tgt();
      t_fall();
      t_fifo();
      finish_test();
   end
endmodule

`default_nettype wire
